// >>> rtl/cgr_counter.v
// Sequencing logic for one 16-bit counter in seven gated reload modes
`timescale 1ns/1ps
`include "cgr_map.vh"

module cgr_counter (
    input wire clk,
    input wire rst_n,
    input wire [`CGR_MODE_W-1:0] counterModeBits,
    input wire countUp,
    input wire countBcd,
    input wire [`CGR_CMD_W-1:0] cmdCode,
    input wire cmdStrobe,
    input wire [`CGR_CNT_W-1:0] loadValue,
    input wire srcPin,
    input wire gatePin,
    input wire toggleSet,
    input wire toggleClear,
    output reg [`CGR_CNT_W-1:0] countValue,
    output reg [`CGR_CNT_W-1:0] holdValue,
    output reg armed,
    output reg running,
    output reg terminalCount,
    output reg toggleOut
);

    // Sequence states, one-hot
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_COUNT = 3'b010;
    localparam [2:0] ST_RELOAD = 3'b100;

    // Decimal-aware step of one counter digit chain
    function [`CGR_CNT_W-1:0] stepCount;
        input [`CGR_CNT_W-1:0] v;
        input up;
        input bcd;
        integer i;
        reg carry;
        reg [3:0] d;
        begin
            stepCount = v;
            carry = 1'b1;
            if (!bcd) begin
                stepCount = up ? v + 16'h0001 : v - 16'h0001;
            end else begin
                for (i = 0; i < 4; i = i + 1) begin
                    d = v[i*4 +: 4];
                    if (carry) begin
                        if (up) begin
                            carry = (d == 4'h9);
                            d = carry ? 4'h0 : d + 4'h1;
                        end else begin
                            carry = (d == 4'h0);
                            d = carry ? 4'h9 : d - 4'h1;
                        end
                    end
                    stepCount[i*4 +: 4] = d;
                end
            end
        end
    endfunction

    // Value whose next count is the end of count
    function isLastCount;
        input [`CGR_CNT_W-1:0] v;
        input up;
        input bcd;
        begin
            if (!up) begin
                isLastCount = (v == `CGR_DOWN_TC);
            end else if (bcd) begin
                isLastCount = (v == `CGR_BCD_UP_TC);
            end else begin
                isLastCount = (v == `CGR_BIN_UP_TC);
            end
        end
    endfunction

    // Mode group flags: alternating, level-gated, edge-started, retriggerable
    function [3:0] modeGroups;
        input [`CGR_MODE_W-1:0] m;
        begin
            case (m)
                `CGR_MODE_J: begin
                    modeGroups = 4'h8;
                end
                `CGR_MODE_K: begin
                    modeGroups = 4'hC;
                end
                `CGR_MODE_L: begin
                    modeGroups = 4'hA;
                end
                `CGR_MODE_N: begin
                    modeGroups = 4'h5;
                end
                `CGR_MODE_O: begin
                    modeGroups = 4'h3;
                end
                `CGR_MODE_Q: begin
                    modeGroups = 4'h5;
                end
                `CGR_MODE_R: begin
                    modeGroups = 4'h3;
                end
                default: begin
                    modeGroups = 4'h0;
                end
            endcase
        end
    endfunction

    // End of count outside the alternating modes: value 3 disarms and stops, any other nonzero value only stops
    function [1:0] endAction;
        input [`CGR_MODE_W-1:0] m;
        begin
            case (m)
                `CGR_MODE_N: begin
                    endAction = 2'h3;
                end
                `CGR_MODE_O: begin
                    endAction = 2'h3;
                end
                `CGR_MODE_R: begin
                    endAction = 2'h1;
                end
                default: begin
                    endAction = 2'h0;
                end
            endcase
        end
    endfunction

    // Synchroniser and edge registers
    reg srcMeta_r;
    reg srcSync_r;
    reg srcPrev_r;
    reg gateMeta_r;
    reg gateSync_r;
    reg gatePrev_r;
    // Sequence state and next values
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg useHold_r;
    reg useHold_nxt;
    reg armed_nxt;
    reg [`CGR_CNT_W-1:0] count_nxt;
    reg [`CGR_CNT_W-1:0] hold_nxt;
    reg tc_nxt;

    // Decoded events and mode groups
    wire srcEdge;
    wire srcQualified;
    wire atLast;
    wire toggleFlip;
    wire [3:0] modeGroup;
    wire gateRise;
    wire gateLevel;
    wire isAlt;
    wire isLevelMode;
    wire isTrigMode;
    wire isRetrig;
    wire cmdArm;
    wire cmdDisarm;
    wire cmdLoad;

    // Two-flop synchronisers and edge registers
    always @(posedge clk) begin
        if (!rst_n) begin
            srcMeta_r <= 1'b0;
            srcSync_r <= 1'b0;
            srcPrev_r <= 1'b0;
            gateMeta_r <= 1'b0;
            gateSync_r <= 1'b0;
            gatePrev_r <= 1'b0;
        end else begin
            srcMeta_r <= srcPin;
            srcSync_r <= srcMeta_r;
            srcPrev_r <= srcSync_r;
            gateMeta_r <= gatePin;
            gateSync_r <= gateMeta_r;
            gatePrev_r <= gateSync_r;
        end
    end

    // Edges seen on the internal clock
    assign srcEdge = srcSync_r & ~srcPrev_r;
    assign gateRise = gateSync_r & ~gatePrev_r;
    assign gateLevel = gateSync_r;

    // Mode groups
    assign modeGroup = modeGroups(counterModeBits);
    assign isAlt = modeGroup[3];
    assign isLevelMode = modeGroup[2];
    assign isTrigMode = modeGroup[1];
    assign isRetrig = modeGroup[0];

    // Source edge that may advance an armed counter
    assign srcQualified = srcEdge & (~isLevelMode | gateLevel);

    // Counter sits on the value before its end of count
    assign atLast = isLastCount(countValue, countUp, countBcd);

    // Flip on the source edge that ends the end-of-count period
    assign toggleFlip = terminalCount & srcEdge & ~tc_nxt;

    // Host command decode
    assign cmdArm = cmdStrobe & (cmdCode == `CGR_CMD_ARM);
    assign cmdDisarm = cmdStrobe & (cmdCode == `CGR_CMD_DISARM);
    assign cmdLoad = cmdStrobe & (cmdCode == `CGR_CMD_LOAD);

    // Next-state logic for the counter sequence
    always @* begin
        state_nxt = state_r;
        armed_nxt = armed;
        useHold_nxt = useHold_r;
        count_nxt = countValue;
        hold_nxt = holdValue;
        tc_nxt = 1'b0;
        if (cmdArm) begin
            armed_nxt = 1'b1;
            useHold_nxt = 1'b1;
            if (!isTrigMode) begin
                state_nxt = ST_COUNT;
            end
        end else if (cmdDisarm) begin
            armed_nxt = 1'b0;
            state_nxt = ST_IDLE;
        end else if (cmdLoad) begin
            count_nxt = loadValue;
        end else begin
            // Gate edge on an armed counter triggers and retriggers
            if (armed && gateRise) begin
                if (isRetrig) begin
                    hold_nxt = countValue;
                    state_nxt = ST_RELOAD;
                end else if (isTrigMode && state_r == ST_IDLE) begin
                    state_nxt = ST_COUNT;
                    useHold_nxt = 1'b1;
                end
                // Idle trigger mode with retrigger also goes to reload on the gate edge
                if (isTrigMode && state_r == ST_IDLE && isRetrig) begin
                    state_nxt = ST_RELOAD;
                end
            end else if (armed && srcQualified) begin
                // Qualified source edge
                case (state_r)
                    ST_RELOAD: begin
                        count_nxt = loadValue;
                        state_nxt = ST_COUNT;
                    end
                    ST_COUNT: begin
                        if (atLast) begin
                            tc_nxt = 1'b1;
                            if (isAlt) begin
                                count_nxt = useHold_r ? holdValue : loadValue;
                                useHold_nxt = ~useHold_r;
                                if (counterModeBits == `CGR_MODE_L && !useHold_r) begin
                                    state_nxt = ST_IDLE;
                                end
                            end else begin
                                count_nxt = loadValue;
                                if (endAction(counterModeBits) == 2'h3) begin
                                    armed_nxt = 1'b0;
                                end
                                if (endAction(counterModeBits) != 2'h0) begin
                                    state_nxt = ST_IDLE;
                                end
                            end
                        end else begin
                            count_nxt = stepCount(countValue, countUp, countBcd);
                        end
                    end
                    default: begin
                        state_nxt = state_r;
                    end
                endcase
            end
        end
    end

    // Sequence registers
    always @(posedge clk) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            armed <= 1'b0;
            useHold_r <= 1'b1;
            countValue <= `CGR_CNT_RST;
            holdValue <= `CGR_CNT_RST;
            terminalCount <= 1'b0;
        end else begin
            state_r <= state_nxt;
            armed <= armed_nxt;
            useHold_r <= useHold_nxt;
            countValue <= count_nxt;
            holdValue <= hold_nxt;
            // End-of-count flag holds for one source period
            if (tc_nxt) begin
                terminalCount <= 1'b1;
            end else if (srcEdge) begin
                terminalCount <= 1'b0;
            end
        end
    end

    // Running flag and toggled output on the trailing end of count
    always @(posedge clk) begin
        if (!rst_n) begin
            running <= 1'b0;
            toggleOut <= 1'b0;
        end else begin
            running <= armed_nxt & (state_nxt != ST_IDLE);
            if (toggleSet) begin
                toggleOut <= 1'b1;
            end else if (toggleClear) begin
                toggleOut <= 1'b0;
            end else if (toggleFlip) begin
                toggleOut <= ~toggleOut;
            end
        end
    end

endmodule

// >>> rtl/cgr_map.vh
// Constants for the gated reload counter sequencer
`ifndef CGR_MAP_VH
`define CGR_MAP_VH
`define CGR_MODE_W 3
`define CGR_MODE_J 3'h0
`define CGR_MODE_K 3'h1
`define CGR_MODE_L 3'h2
`define CGR_MODE_N 3'h3
`define CGR_MODE_O 3'h4
`define CGR_MODE_Q 3'h5
`define CGR_MODE_R 3'h6
`define CGR_CMD_W 2
`define CGR_CMD_NONE 2'h0
`define CGR_CMD_ARM 2'h1
`define CGR_CMD_DISARM 2'h2
`define CGR_CMD_LOAD 2'h3
`define CGR_CNT_W 16
`define CGR_CNT_RST 16'h0000
`define CGR_DOWN_TC 16'h0001
`define CGR_BIN_UP_TC 16'hFFFF
`define CGR_BCD_UP_TC 16'h9999
`endif

// >>> verif/cgr_counter_sva.sv
// Checker for the gated reload counter sequencer
`timescale 1ns/1ps
`include "cgr_map.vh"
module cgr_counter_sva (
    input wire clk,
    input wire rst_n,
    input wire [`CGR_MODE_W-1:0] counterModeBits,
    input wire countUp,
    input wire countBcd,
    input wire [`CGR_CMD_W-1:0] cmdCode,
    input wire cmdStrobe,
    input wire [`CGR_CNT_W-1:0] loadValue,
    input wire srcPin,
    input wire gatePin,
    input wire toggleSet,
    input wire toggleClear,
    input wire [`CGR_CNT_W-1:0] countValue,
    input wire [`CGR_CNT_W-1:0] holdValue,
    input wire armed,
    input wire running,
    input wire terminalCount,
    input wire toggleOut
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_ARM_TAKE: assert property (cmdStrobe && cmdCode == `CGR_CMD_ARM |=> armed)
        else $error("arm not taken");
    AST_HALT_TAKE: assert property (cmdStrobe && cmdCode == `CGR_CMD_DISARM |=> !armed && !running)
        else $error("halt not taken");
    AST_RUN_ARMED: assert property (running |-> armed)
        else $error("running while disarmed");
    AST_IDLE_STILL: assert property (!armed && !$past(armed) && !$past(cmdStrobe) |-> $stable(countValue))
        else $error("disarmed counter moved");
    AST_HOLD_KEEP: assert property (counterModeBits <= `CGR_MODE_L && $past(counterModeBits) <= `CGR_MODE_L |-> $stable(holdValue))
        else $error("hold changed in alternating mode");
    AST_TC_VALUE: assert property ($rose(terminalCount) && !countUp |-> $past(countValue) == `CGR_DOWN_TC)
        else $error("end of count at wrong value");
    AST_TC_STANDS: assert property ($rose(terminalCount) |=> terminalCount)
        else $error("end of count too short");
    AST_TOGGLE: assert property ($changed(toggleOut) |-> $fell(terminalCount) || $past(toggleSet) || $past(toggleClear))
        else $error("toggle flipped without end of count");
    cover property ($rose(terminalCount));
    cover property ($changed(holdValue));
    cover property ($fell(armed));
endmodule
bind cgr_counter cgr_counter_sva i_sva (.clk(clk), .rst_n(rst_n),
    .counterModeBits(counterModeBits), .countUp(countUp), .countBcd(countBcd), .cmdCode(cmdCode),
    .cmdStrobe(cmdStrobe), .loadValue(loadValue), .srcPin(srcPin), .gatePin(gatePin),
    .toggleSet(toggleSet), .toggleClear(toggleClear), .countValue(countValue),
    .holdValue(holdValue), .armed(armed), .running(running), .terminalCount(terminalCount),
    .toggleOut(toggleOut));

// >>> verif/cgr_far_model.sv
// Far side model: count source and gate signal
`timescale 1ns/1ps
module cgr_far_model (
    input wire clk,
    output reg srcPin,
    output reg gatePin
);
    initial begin
        srcPin = 1'b0;
        gatePin = 1'b0;
    end
    // One source pulse, slow enough for the two-flop synchroniser
    task src_pulse;
        begin
            @(negedge clk) srcPin = 1'b1;
            repeat (3) @(negedge clk);
            srcPin = 1'b0;
            repeat (3) @(negedge clk);
        end
    endtask
    // Gate level change, then time for the edge to land
    task gate_set(input v);
        begin
            @(negedge clk) gatePin = v;
            repeat (5) @(negedge clk);
        end
    endtask
endmodule

// >>> verif/counter_gated_reload_modes_bench.sv
// Directed bench for the gated reload counter sequencer
`timescale 1ns/1ps
`include "cgr_map.vh"
module counter_gated_reload_modes_bench;
    reg clk, rst_n, stb, tClr;
    reg up, bcd, tSet;
    reg [2:0] mode;
    reg [1:0] cmd;
    reg [15:0] ld;
    reg [159:0] seq;
    wire [15:0] cnt, hold;
    wire armed, run, tc, tog, src, gate;
    integer error_cnt = 0;
    integer num_checks = 0;
    integer i;
    cgr_far_model i_far (.clk(clk), .srcPin(src), .gatePin(gate));
    cgr_counter i_dut (.clk(clk), .rst_n(rst_n), .counterModeBits(mode), .countUp(up),
        .countBcd(bcd), .cmdCode(cmd), .cmdStrobe(stb), .loadValue(ld), .srcPin(src),
        .gatePin(gate), .toggleSet(tSet), .toggleClear(tClr), .countValue(cnt),
        .holdValue(hold), .armed(armed), .running(run), .terminalCount(tc), .toggleOut(tog));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task final_report;
        begin
            if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    task chk(input [15:0] g, input [15:0] e);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("[ERR] %0t got %h want %h", $time, g, e);
            end
        end
    endtask
    // Mode is changed only while disarmed
    task do_cmd(input [1:0] c, input [2:0] m);
        begin
            @(negedge clk) cmd = c;
            stb = 1'b1;
            mode = m;
            @(negedge clk) stb = 1'b0;
            cmd = `CGR_CMD_NONE;
            @(negedge clk);
        end
    endtask
    task t_oneshot;
        begin
            ld = 16'h0005;
            do_cmd(`CGR_CMD_LOAD, `CGR_MODE_R);
            ld = 16'h0003;
            do_cmd(`CGR_CMD_ARM, `CGR_MODE_R);
            i_far.gate_set(1'b1);
            chk(hold, 16'h0005);
            i_far.src_pulse;
            chk(cnt, 16'h0003);
            i_far.src_pulse;
            chk(cnt, 16'h0002);
            i_far.gate_set(1'b0);
            i_far.src_pulse;
            chk(cnt, 16'h0001);
            i_far.src_pulse;
            chk({tc, cnt[14:0]}, 16'h8003);
            i_far.src_pulse;
            chk({run, cnt[14:0]}, 16'h0003);
        end
    endtask
    task t_alt;
        begin
            do_cmd(`CGR_CMD_DISARM, `CGR_MODE_R);
            ld = 16'h0002;
            @(negedge clk) tClr = 1'b1;
            @(negedge clk) tClr = 1'b0;
            do_cmd(`CGR_CMD_ARM, `CGR_MODE_J);
            seq = {16'h0002, 16'h0001, 16'h0005, 16'h0004, 16'h0003,
                16'h0002, 16'h0001, 16'h0002, 16'h0001, 16'h0005};
            for (i = 0; i < 10; i = i + 1) begin
                i_far.src_pulse;
                chk(cnt, seq[(9 - i) * 16 +: 16]);
                chk(tog, {15'h0000, i > 2 && i < 8});
            end
            do_cmd(`CGR_CMD_DISARM, `CGR_MODE_J);
            i_far.src_pulse;
            chk(cnt, 16'h0005);
        end
    endtask
    task t_gated;
        begin
            do_cmd(`CGR_CMD_ARM, `CGR_MODE_K);
            i_far.src_pulse;
            chk(cnt, 16'h0005);
            i_far.gate_set(1'b1);
            for (i = 0; i < 6; i = i + 1) begin
                i_far.src_pulse;
                chk(cnt, i == 4 ? 16'h0005 : i == 5 ? 16'h0004 : 16'h0004 - i[15:0]);
            end
        end
    endtask
    task t_edge;
        begin
            do_cmd(`CGR_CMD_DISARM, `CGR_MODE_K);
            do_cmd(`CGR_CMD_ARM, `CGR_MODE_O);
            i_far.gate_set(1'b0);
            i_far.gate_set(1'b1);
            chk(hold, 16'h0004);
            i_far.src_pulse;
            chk(cnt, 16'h0002);
            i_far.src_pulse;
            chk(cnt, 16'h0001);
            i_far.src_pulse;
            chk({armed, cnt[14:0]}, 16'h0002);
            i_far.gate_set(1'b0);
            i_far.gate_set(1'b1);
            i_far.src_pulse;
            chk(hold ^ cnt, 16'h0006);
        end
    endtask
    // Synchronized rate mode, decimal up counting, set then toggle
    task t_sync;
        begin
            do_cmd(`CGR_CMD_DISARM, `CGR_MODE_Q);
            up = 1'b1;
            bcd = 1'b1;
            ld = 16'h9998;
            do_cmd(`CGR_CMD_LOAD, `CGR_MODE_Q);
            @(negedge clk) tSet = 1'b1;
            @(negedge clk) tSet = 1'b0;
            chk(tog, 16'h0001);
            do_cmd(`CGR_CMD_ARM, `CGR_MODE_Q);
            i_far.src_pulse;
            chk(cnt, 16'h9999);
            i_far.src_pulse;
            chk(cnt, 16'h9998);
            chk(tc, 16'h0001);
            i_far.gate_set(1'b0);
            i_far.gate_set(1'b1);
            chk(hold, 16'h9998);
            ld = 16'h0010;
            i_far.src_pulse;
            chk(cnt, 16'h0010);
            chk(tog, 16'h0000);
            i_far.src_pulse;
            chk(cnt, 16'h0011);
        end
    endtask
    initial begin
        rst_n = 1'b0;
        stb = 1'b0;
        tClr = 1'b1;
        tSet = 1'b0;
        up = 1'b0;
        bcd = 1'b0;
        cmd = `CGR_CMD_NONE;
        mode = `CGR_MODE_R;
        ld = 16'h0000;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        tClr = 1'b0;
        t_oneshot;
        t_alt;
        t_gated;
        t_edge;
        t_sync;
        final_report;
    end
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (2000) @(posedge clk);
        error_cnt = error_cnt + 1;
        final_report;
    end
endmodule
